// File: hdl/dtp_pin_mux.sv
// pin multiplexer for debug, trace, serial controller 1 and strap pads
// assumes core-side controls are on mclk; pads and debug clock are not
`timescale 1ns/100ps

module dtp_pin_mux
    import dtp_pkg::*;
(
    input  wire logic                mclk,
    input  wire logic                sys_rst,
    input  wire logic                dbg_clk,
    input  wire logic                chip_reset_n,
    input  wire logic [NUM_PADS-1:0] pad_i,
    output logic      [NUM_PADS-1:0] pad_o,
    output logic      [NUM_PADS-1:0] pad_oe_n,
    output dtp_pull_t                pad_pull,
    input  wire logic [15:0]         port_a_high_config,
    input  wire logic [15:0]         port_b_low_config,
    input  wire logic [15:0]         port_c_low_config,
    input  wire logic [15:0]         debug_pin_config,
    input  wire dtp_ser1_mode_t      ser1_mode_select,
    input  wire logic                ser1_spi_control,
    input  wire dtp_trace_cfg_t      trace_cfg,
    input  wire logic                packet_trace_port,
    input  wire logic                packet_trace_data_out,
    input  wire logic                sync_trace_bit3,
    input  wire logic                sync_trace_clock,
    input  wire logic                async_trace_out,
    input  wire logic                ser1_spi_slave_out,
    input  wire logic                ser1_uart_tx,
    input  wire logic                scan_data_out,
    input  wire logic                swd_data_out,
    input  wire logic                swd_data_drive,
    input  wire logic [NUM_PADS-1:0] gpio_out,
    input  wire logic [NUM_PADS-1:0] gpio_drive,
    output logic      [NUM_PADS-1:0] gpio_in,
    output logic                     ser1_spi_slave_in,
    output logic                     ser1_uart_rx,
    output logic                     ser1_spi_slave_active,
    output logic                     ext_interrupt_a,
    output logic                     scan_data_in,
    output logic                     scan_mode_select,
    output logic                     swd_data_in,
    output logic                     swd_mode,
    output logic                     boot_strap_n,
    output logic                     boot_to_monitor
);

    logic [NUM_PADS-1:0] pad_m_r;
    logic [NUM_PADS-1:0] pad_s_r;
    logic                crst_m_r;
    logic                crst_s_r;
    logic                rst_any;
    logic                strap_after_r;
    logic                boot_r;
    logic                swd_mode_r;
    logic                tgl_m_r;
    logic                tgl_s_r;
    logic                tgl_d_r;
    logic                lrst_m_r;
    logic                lrst_s_r;
    logic                tgl_l_r;
    dtp_seq_state_t      seq_r;
    logic [5:0]          ones_r;
    logic [15:0]         key_r;
    logic [3:0]          bit_r;
    logic [NUM_PADS-1:0] pad_o_nxt;
    logic [NUM_PADS-1:0] pad_oe_n_nxt;
    logic [NUM_PADS-1:0] pad_o_r;
    logic [NUM_PADS-1:0] pad_oe_n_r;
    dtp_pull_t           pull_nxt;
    dtp_pull_t           pull_r;
    logic                released;
    logic                scan_mode;
    logic                spi_slave;
    logic                uart_sel;
    logic                pa_alt;
    logic                pb_dat_alt;
    logic                pb_clk_alt;
    logic                pc_atr_alt;
    logic                pkt_ok;
    logic                tr3_ok;
    logic                atr_ok;
    logic                trclk_ok;

    // two-flop synchronisers on every pad input
    genvar g;
    generate
        for (g = 0; g < NUM_PADS; g++) begin : g_sync
            always_ff @(posedge mclk) begin
                pad_m_r[g] <= pad_i[g];
                pad_s_r[g] <= pad_m_r[g];
            end
        end
    endgenerate

    always_ff @(posedge mclk) begin
        crst_m_r <= ~chip_reset_n;
        crst_s_r <= crst_m_r;
    end

    // pad pulled up outside, so a floating reset pin reads released
    assign rst_any = sys_rst | crst_s_r;

    // strap caught while reset is held and on the first cycle after
    always_ff @(posedge mclk) begin
        if (rst_any) begin
            boot_r        <= ~pad_s_r[IDX_PORT_A_BIT5_PIN];
            strap_after_r <= 1'b1;
        end else if (strap_after_r) begin
            boot_r        <= ~pad_s_r[IDX_PORT_A_BIT5_PIN];
            strap_after_r <= 1'b0;
        end
    end

    // link domain: reset brought over by two flops
    always_ff @(posedge dbg_clk) begin
        lrst_m_r <= rst_any;
        lrst_s_r <= lrst_m_r;
    end

    // key detector on the mode-select pad, clocked by the debugger
    always_ff @(posedge dbg_clk) begin
        if (lrst_s_r) begin
            seq_r   <= SEQ_ONES;
            ones_r  <= 6'h00;
            key_r   <= 16'h0000;
            bit_r   <= 4'h0;
            tgl_l_r <= 1'b0;
        end else begin
            unique case (seq_r)
                SEQ_ONES: begin
                    if (pad_i[IDX_PORT_C_BIT4_PIN]) begin
                        if (ones_r != SEQ_ONES_MAX)
                            ones_r <= ones_r + 6'h01;
                    end else if (ones_r == SEQ_ONES_MAX) begin
                        seq_r <= SEQ_KEYB;
                        key_r <= {1'b0, key_r[15:1]};
                        bit_r <= 4'h1;
                    end else begin
                        ones_r <= 6'h00;
                    end
                end
                SEQ_KEYB: begin
                    key_r <= {pad_i[IDX_PORT_C_BIT4_PIN], key_r[15:1]};
                    bit_r <= bit_r + 4'h1;
                    if (bit_r == SEQ_KEY_LAST) begin
                        seq_r  <= SEQ_ONES;
                        ones_r <= 6'h00;
                        if ({pad_i[IDX_PORT_C_BIT4_PIN], key_r[15:1]}
                            == SEQ_KEY)
                            tgl_l_r <= ~tgl_l_r;
                    end
                end
            endcase
        end
    end

    // toggle crossing back to the core clock
    always_ff @(posedge mclk) begin
        tgl_m_r <= tgl_l_r;
        tgl_s_r <= tgl_m_r;
        tgl_d_r <= tgl_s_r;
    end

    // reset beats a switch event arriving in the same cycle
    always_ff @(posedge mclk) begin
        if (rst_any)
            swd_mode_r <= 1'b0;
        else if (tgl_s_r != tgl_d_r)
            swd_mode_r <= 1'b1;
    end

    assign released   = debug_pin_config[DBG_RELEASE];
    assign scan_mode  = ~swd_mode_r;
    assign uart_sel   = ser1_mode_select == SER1_UART;
    assign spi_slave  = (ser1_mode_select == SER1_SPI)
                        & ser1_spi_control;
    assign pa_alt     = port_a_high_config[PA_HI_ALT_HI:PA_HI_ALT_LO]
                        == CFG_ALT_OUT;
    assign pb_dat_alt = port_b_low_config[PB_LO_DAT_HI:PB_LO_DAT_LO]
                        == CFG_ALT_OUT;
    assign pb_clk_alt = port_b_low_config[PB_LO_CLK_HI:PB_LO_CLK_LO]
                        == CFG_ALT_OUT;
    assign pc_atr_alt = port_c_low_config[PC_LO_ATR_HI:PC_LO_ATR_LO]
                        == CFG_ALT_OUT;
    assign pkt_ok     = pa_alt & packet_trace_port
                        & ~trace_cfg.enable;
    assign tr3_ok     = pa_alt & trace_cfg.enable
                        & trace_cfg.sync_4wire;
    assign atr_ok     = pc_atr_alt & trace_cfg.enable
                        & trace_cfg.async_mode & swd_mode_r;
    assign trclk_ok   = pb_clk_alt & trace_cfg.enable;

    always_comb begin
        pad_o_nxt    = gpio_out;
        pad_oe_n_nxt = ~gpio_drive;
        pull_nxt     = '0;

        // strap pad stays input while reset holds
        if (rst_any) begin
            pad_oe_n_nxt[IDX_PORT_A_BIT5_PIN] = 1'b1;
        end else if (pkt_ok) begin
            pad_o_nxt[IDX_PORT_A_BIT5_PIN]    = packet_trace_data_out;
            pad_oe_n_nxt[IDX_PORT_A_BIT5_PIN] = 1'b0;
        end else if (tr3_ok) begin
            pad_o_nxt[IDX_PORT_A_BIT5_PIN]    = sync_trace_bit3;
            pad_oe_n_nxt[IDX_PORT_A_BIT5_PIN] = 1'b0;
        end

        if (pb_dat_alt & spi_slave) begin
            pad_o_nxt[IDX_PORT_B_BIT1_PIN]    = ser1_spi_slave_out;
            pad_oe_n_nxt[IDX_PORT_B_BIT1_PIN] = 1'b0;
        end else if (pb_dat_alt & uart_sel) begin
            pad_o_nxt[IDX_PORT_B_BIT1_PIN]    = ser1_uart_tx;
            pad_oe_n_nxt[IDX_PORT_B_BIT1_PIN] = 1'b0;
        end

        if (scan_mode & ~released) begin
            pad_o_nxt[IDX_PORT_C_BIT2_PIN]    = scan_data_out;
            pad_oe_n_nxt[IDX_PORT_C_BIT2_PIN] = 1'b0;
        end else if (atr_ok) begin
            pad_o_nxt[IDX_PORT_C_BIT2_PIN]    = async_trace_out;
            pad_oe_n_nxt[IDX_PORT_C_BIT2_PIN] = 1'b0;
        end

        // scan data in is input-only in scan mode until freed
        if (scan_mode & ~released)
            pad_oe_n_nxt[IDX_PORT_C_BIT3_PIN] = 1'b1;

        if (~released) begin
            pad_o_nxt[IDX_PORT_C_BIT4_PIN]    = swd_data_out;
            pad_oe_n_nxt[IDX_PORT_C_BIT4_PIN] =
                ~(swd_mode_r & swd_data_drive);
        end

        if (trclk_ok) begin
            pad_o_nxt[IDX_PORT_B_BIT0_PIN]    = sync_trace_clock;
            pad_oe_n_nxt[IDX_PORT_B_BIT0_PIN] = 1'b0;
        end

        if (scan_mode & ~released) begin
            pull_nxt.clk_pull_dn                  = 1'b1;
            pull_nxt.pull_up[IDX_PORT_C_BIT2_PIN] = 1'b1;
            pull_nxt.pull_up[IDX_PORT_C_BIT3_PIN] = 1'b1;
            pull_nxt.pull_up[IDX_PORT_C_BIT4_PIN] = 1'b1;
        end
    end

    // trace clock passes the same flop as its data: no skew between them
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pad_o_r    <= '0;
            pad_oe_n_r <= '1;
            pull_r     <= '0;
        end else begin
            pad_o_r    <= pad_o_nxt;
            pad_oe_n_r <= pad_oe_n_nxt;
            pull_r     <= pull_nxt;
        end
    end

    assign pad_o    = pad_o_r;
    assign pad_oe_n = pad_oe_n_r;
    assign pad_pull = pull_r;

    // core-facing inputs; serial, scan and swd data idle high when not selected, slave-active low then
    assign ser1_spi_slave_in = spi_slave ?
                               pad_s_r[IDX_PORT_B_BIT2_PIN] : 1'b1;
    assign ser1_uart_rx      = uart_sel ?
                               pad_s_r[IDX_PORT_B_BIT2_PIN] : 1'b1;
    assign ser1_spi_slave_active = spi_slave;
    assign ext_interrupt_a   = pad_s_r[IDX_PORT_B_BIT0_PIN];
    assign scan_data_in      = (scan_mode & ~released) ?
                               pad_s_r[IDX_PORT_C_BIT3_PIN] : 1'b1;
    assign scan_mode_select  = (scan_mode & ~released) ?
                               pad_s_r[IDX_PORT_C_BIT4_PIN] : 1'b1;
    assign swd_data_in       = (swd_mode_r & ~released) ?
                               pad_s_r[IDX_PORT_C_BIT4_PIN] : 1'b1;
    assign gpio_in           = pad_s_r;
    // dbg_clk is scan clock or serial-wire clock by swd_mode alone
    assign swd_mode          = swd_mode_r;
    assign boot_strap_n      = ~boot_r;
    assign boot_to_monitor   = boot_r;

endmodule

// File: inc/dtp_pkg.sv
// constants and carrier types for the debug and trace pin multiplexer
// assumes one core clock domain plus the debugger's clock domain
package dtp_pkg;

    // pad indices within the seven multiplexed pads
    localparam int NUM_PADS            = 7;
    localparam int IDX_PORT_A_BIT5_PIN = 0;
    localparam int IDX_PORT_B_BIT1_PIN = 1;
    localparam int IDX_PORT_B_BIT2_PIN = 2;
    localparam int IDX_PORT_C_BIT2_PIN = 3;
    localparam int IDX_PORT_C_BIT3_PIN = 4;
    localparam int IDX_PORT_C_BIT4_PIN = 5;
    localparam int IDX_PORT_B_BIT0_PIN = 6;

    // config field positions and the alternate-output code
    localparam int PA_HI_ALT_HI  = 7;
    localparam int PA_HI_ALT_LO  = 4;
    localparam int PB_LO_DAT_HI  = 7;
    localparam int PB_LO_DAT_LO  = 4;
    localparam int PB_LO_CLK_HI  = 3;
    localparam int PB_LO_CLK_LO  = 0;
    localparam int PC_LO_ATR_HI  = 11;
    localparam int PC_LO_ATR_LO  = 8;
    localparam int DBG_RELEASE   = 5;
    localparam logic [3:0] CFG_ALT_OUT = 4'h9;

    // serial-wire switching sequence, key sent least significant bit first
    localparam int          SEQ_MIN_ONES = 50;
    localparam logic [5:0]  SEQ_ONES_MAX = 6'(SEQ_MIN_ONES);
    localparam logic [15:0] SEQ_KEY      = 16'he79e;
    localparam logic [3:0]  SEQ_KEY_LAST = 4'hf;

    // serial controller 1 mode selection
    typedef enum logic [1:0] {
        SER1_OFF  = 2'h0,
        SER1_UART = 2'h1,
        SER1_SPI  = 2'h2
    } dtp_ser1_mode_t;

    typedef struct packed {
        logic enable;
        logic async_mode;
        logic sync_4wire;
    } dtp_trace_cfg_t;

    typedef struct packed {
        logic [NUM_PADS-1:0] pull_up;
        logic [NUM_PADS-1:0] pull_dn;
        logic                clk_pull_dn;
    } dtp_pull_t;

    typedef enum logic [0:0] {
        SEQ_ONES = 1'b0,
        SEQ_KEYB = 1'b1
    } dtp_seq_state_t;

endpackage

// File: verif/dtp_debugger_model.sv
// debugger model: drives the debug clock and the mode-select line
// assumes a pull-up on mode-select, so a released line reads high
`timescale 1ns/100ps
module dtp_debugger_model (
    output logic dbg_clk,
    output logic tms
);
    initial begin
        dbg_clk = 1'b0;
        tms     = 1'b1;
    end
    // clock stands still between frames; data changes on the low phase
    task automatic run(input int ones, input int nkey,
                       input logic [15:0] key);
        #3;
        for (int i = 0; i < ones + nkey; i++) begin
            if (i < ones)
                tms = 1'b1;
            else
                tms = key[i-ones];
            #6 dbg_clk = 1'b1;
            #6 dbg_clk = 1'b0;
        end
        tms = 1'b1;
    endtask
endmodule

// File: verif/dtp_pin_mux_monitor.sv
// checker for the debug and trace pin multiplexer
// assumes it is bound onto dtp_pin_mux and watches mclk only
`timescale 1ns/100ps
module dtp_pin_mux_monitor
    import dtp_pkg::*;
(
    input wire logic                mclk,
    input wire logic                sys_rst,
    input wire logic                chip_reset_n,
    input wire logic [NUM_PADS-1:0] pad_i,
    input wire logic [NUM_PADS-1:0] pad_o,
    input wire logic [NUM_PADS-1:0] pad_oe_n,
    input wire dtp_pull_t           pad_pull,
    input wire logic [15:0]         port_a_high_config,
    input wire logic [15:0]         port_b_low_config,
    input wire logic [15:0]         debug_pin_config,
    input wire dtp_ser1_mode_t      ser1_mode_select,
    input wire logic                ser1_spi_control,
    input wire dtp_trace_cfg_t      trace_cfg,
    input wire logic                packet_trace_port,
    input wire logic                packet_trace_data_out,
    input wire logic                sync_trace_clock,
    input wire logic                ser1_spi_slave_out,
    input wire logic                ser1_uart_tx,
    input wire logic                scan_data_out,
    input wire logic                ser1_spi_slave_active,
    input wire logic                ext_interrupt_a,
    input wire logic                scan_data_in,
    input wire logic                swd_mode
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic pb_alt;
    logic scan_on;
    assign pb_alt  = port_b_low_config[7:4] == CFG_ALT_OUT;
    assign scan_on = !swd_mode && !debug_pin_config[DBG_RELEASE];
    // pad registers only hold mux results once a run cycle has passed
    sequence ran_one;
        !$past(sys_rst);
    endsequence
    sequence chip_rst_held;
        !chip_reset_n [*5];
    endsequence
    a_uart_tx_route:
    assert property (ran_one ##0 $past(pb_alt && ser1_mode_select ==
        SER1_UART) |-> !pad_oe_n[1] && pad_o[1] == $past(ser1_uart_tx))
        else $error("uart tx missing on pad");
    a_spi_out_route:
    assert property (ran_one ##0 $past(pb_alt && ser1_spi_control &&
        ser1_mode_select == SER1_SPI) |-> !pad_oe_n[1] &&
        pad_o[1] == $past(ser1_spi_slave_out))
        else $error("spi out missing on pad");
    a_spi_active_sel:
    assert property (ser1_spi_slave_active == (ser1_spi_control &&
        ser1_mode_select == SER1_SPI)) else $error("spi slave select");
    a_scan_tdo_drive:
    assert property (ran_one ##0 $past(scan_on) |-> !pad_oe_n[3] &&
        pad_o[3] == $past(scan_data_out)) else $error("scan out lost");
    a_scan_after_rst:
    assert property ($past(sys_rst) |-> !swd_mode)
        else $error("serial-wire mode kept over reset");
    a_chip_rst_scan:
    assert property (chip_rst_held |-> !swd_mode)
        else $error("chip reset left serial-wire mode");
    a_pull_in_scan:
    assert property (ran_one ##0 $past(scan_on) |-> pad_pull.clk_pull_dn
        && (pad_pull.pull_up[5:3] == 3'h7)) else $error("scan pulls off");
    a_irq_a_sync:
    assert property (ran_one ##0 !$past(sys_rst, 2) |->
        ext_interrupt_a == $past(pad_i[6], 2)) else $error("irq a path");
    a_trace_clk_out:
    assert property (ran_one ##0 $past(trace_cfg.enable &&
        port_b_low_config[3:0] == CFG_ALT_OUT) |-> !pad_oe_n[6] &&
        pad_o[6] == $past(sync_trace_clock)) else $error("trace clock");
    a_pkt_data_out:
    assert property (ran_one ##0 $past(!trace_cfg.enable &&
        packet_trace_port && port_a_high_config[7:4] == CFG_ALT_OUT)
        |-> pad_o[0] == $past(packet_trace_data_out))
        else $error("packet data missing");
    a_tdi_released:
    assert property (!scan_on |-> scan_data_in) else $error("scan in");
endmodule

bind dtp_pin_mux dtp_pin_mux_monitor u_dtp_pin_mux_monitor (.*);

// File: verif/dtp_pin_mux_test.sv
// self-checking bench for the debug and trace pin multiplexer
// assumes the debugger model owns the debug clock and mode-select
`timescale 1ns/100ps
module dtp_pin_mux_test;
    import dtp_pkg::*;
    logic mclk, sys_rst, chip_reset_n, dbg_clk, tms;
    logic [NUM_PADS-1:0] pad_drv, pad_o, pad_oe_n, gpio_in;
    logic [NUM_PADS-1:0] gpio_out, gpio_drive;
    wire  [NUM_PADS-1:0] pad_i;
    logic [15:0] port_a_high_config, port_b_low_config;
    logic [15:0] port_c_low_config, debug_pin_config;
    dtp_ser1_mode_t ser1_mode_select;
    dtp_trace_cfg_t trace_cfg;
    dtp_pull_t      pad_pull;
    logic ser1_spi_control, packet_trace_port, packet_trace_data_out;
    logic sync_trace_bit3, sync_trace_clock, async_trace_out;
    logic ser1_spi_slave_out, ser1_uart_tx, scan_data_out;
    logic swd_data_out, swd_data_drive, ser1_spi_slave_in, ser1_uart_rx;
    logic ser1_spi_slave_active, ext_interrupt_a, scan_data_in;
    logic scan_mode_select, swd_data_in, swd_mode;
    logic boot_strap_n, boot_to_monitor;
    int   error_cnt = 0;
    int   num_checks = 0;
    // mode-select is shared: the design wins while it drives
    assign pad_i = {pad_drv[6], pad_oe_n[5] ? tms : pad_o[5], pad_drv[4:0]};
    dtp_pin_mux u_dtp_pin_mux (.*);
    dtp_debugger_model u_dtp_debugger_model (.dbg_clk(dbg_clk), .tms(tms));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic t_defaults;
        @(posedge mclk);
        scan_data_out <= 1'b0;
        pad_drv[4]    <= 1'b0;
        pad_drv[6]    <= 1'b0;
        settle(2);
        chk(pad_o[3], 0);
        chk(pad_oe_n[3], 0);
        chk(swd_mode, 0);
        chk(pad_pull.clk_pull_dn, 1);
        chk(scan_data_in, 0);
        chk({ext_interrupt_a, gpio_in[6]}, 0);
        // release hands the debug pads back to gpio
        @(posedge mclk);
        debug_pin_config[DBG_RELEASE] <= 1'b1;
        settle(2);
        chk({pad_oe_n[3], pad_o[3]}, 1);
        chk(scan_data_in, 1);
        chk(pad_pull.clk_pull_dn, 0);
        @(posedge mclk);
        debug_pin_config[DBG_RELEASE] <= 1'b0;
        $display("t_defaults done");
    endtask
    task automatic t_serial;
        dtp_ser1_mode_t m;
        for (int i = 1; i < 3; i++) begin
            m = dtp_ser1_mode_t'(i);
            @(posedge mclk);
            ser1_mode_select     <= m;
            port_b_low_config    <= 16'h0090;
            pad_drv[2]           <= 1'b0;
            settle(3);
            chk(pad_o[1], m == SER1_UART);
            chk(ser1_uart_rx, m != SER1_UART);
            chk(ser1_spi_slave_in, m == SER1_UART);
            chk(ser1_spi_slave_active, m == SER1_SPI);
        end
        @(posedge mclk);
        ser1_spi_control <= 1'b0;
        settle(2);
        chk(ser1_spi_slave_active, 0);
        $display("t_serial done");
    endtask
    task automatic t_trace;
        @(posedge mclk);
        port_a_high_config <= 16'h0090;
        port_b_low_config  <= 16'h0009;
        packet_trace_port  <= 1'b1;
        packet_trace_data_out <= 1'b0;
        settle(2);
        chk(pad_o[0], 0);
        @(posedge mclk);
        trace_cfg <= '{enable: 1'b1, async_mode: 1'b0, sync_4wire: 1'b1};
        sync_trace_bit3 <= 1'b1;
        gpio_out[0]     <= 1'b0;
        settle(2);
        chk(pad_o[0], 1);
        chk({pad_oe_n[6], pad_o[6]}, 0);
        $display("t_trace done");
    endtask
    task automatic t_strap;
        for (int s = 0; s < 2; s++) begin
            @(posedge mclk);
            pad_drv[0]   <= s[0];
            chip_reset_n <= 1'b0;
            settle(8);
            @(posedge mclk);
            chip_reset_n <= 1'b1;
            settle(8);
            chk(boot_to_monitor, !s[0]);
            chk(boot_strap_n, s[0]);
        end
        $display("t_strap done");
    endtask
    task automatic t_swd;
        // link reset may eat two clocks; key is wrong only in its top bit
        u_dtp_debugger_model.run(52, 16, 16'h679e);
        settle(8);
        chk(swd_mode, 0);
        u_dtp_debugger_model.run(50, 16, SEQ_KEY);
        for (int w = 0; swd_mode !== 1'b1; w++) begin
            if (w > 20) begin
                error_cnt++;
                tally_and_finish();
            end
            settle(1);
        end
        chk(scan_data_in, 1);
        @(posedge mclk);
        trace_cfg         <= '{enable: 1'b1, async_mode: 1'b1,
                               sync_4wire: 1'b0};
        port_c_low_config <= 16'h0900;
        swd_data_drive    <= 1'b1;
        swd_data_out      <= 1'b0;
        async_trace_out   <= 1'b0;
        settle(4);
        chk({pad_oe_n[3], pad_o[3]}, 0);
        chk({pad_oe_n[5], pad_o[5]}, 0);
        chk({swd_data_in, scan_mode_select}, 1);
        @(posedge mclk);
        chip_reset_n <= 1'b0;
        settle(6);
        chk(swd_mode, 0);
        $display("t_swd done");
    endtask
    initial begin
        {sys_rst, chip_reset_n, pad_drv, gpio_out, gpio_drive} = '1;
        {port_a_high_config, port_b_low_config} = '0;
        {port_c_low_config, debug_pin_config} = '0;
        ser1_mode_select = SER1_OFF;
        trace_cfg        = '0;
        {ser1_spi_control, packet_trace_port, packet_trace_data_out} = 3'h7;
        {sync_trace_bit3, sync_trace_clock, async_trace_out} = 3'h1;
        {ser1_spi_slave_out, ser1_uart_tx, scan_data_out} = 3'h3;
        {swd_data_out, swd_data_drive} = 2'h2;
        u_dtp_debugger_model.run(4, 0, 16'h0000);
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        t_defaults();
        t_serial();
        t_trace();
        t_strap();
        t_swd();
        tally_and_finish();
    end
endmodule
